/* rtl/srw_pkg.sv */
// constants, state encoding and timing for the supply/reset watchdog block
// Function
// - reset_out_n low on supply, manual, watchdog
// - reset_out always complement of reset_out_n
// - hold reset_out_n for full hold period
// - hold reset_out for full hold period
// - manual_reset_in_n low asserts reset while low
// - at least 140ms after manual reset release
// - debounce manual_reset_in_n internally
// - no kick edge past timeout expires watchdog
// - clear watchdog on reset, manual, kick edge
// - undriven kick input gives no watchdog reset
// - supply recovery starts internal hold timer
// - watchdog timeout nominally 1.6s
// - watchdog cleared and stopped during reset
// - kick pulses of 50ns are valid edges
// - drive kick low 7/8, high last 1/8
package srw_pkg;

  // clock
  localparam longint CLK_PERIOD_NS   = 10;
  // reset hold period, least time, rounds up
  localparam longint RESET_HOLD_NS   = 140_000_000;
  localparam int     HOLD_CYC        = int'((RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // watchdog timeout, nominal, rounds down
  localparam longint WD_TIMEOUT_NS   = 1_600_000_000;
  localparam int     WD_CYC          = int'(WD_TIMEOUT_NS / CLK_PERIOD_NS);
  // shortest kick pulse that must be seen
  localparam longint KICK_PULSE_NS   = 50;
  localparam int     KICK_PULSE_CYC  = int'(KICK_PULSE_NS / CLK_PERIOD_NS);
  // manual reset must be stable this long before it is believed
  localparam longint MR_DEBOUNCE_NS  = 1_000;
  localparam int     MR_DEBOUNCE_CYC = int'((MR_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // plain synchroniser, no extra filtering
  localparam int     SYNC_ONLY_CYC   = 1;
  // internal kick driver goes high for the last eighth
  localparam int     KICK_HIGH_NUM   = 7;
  localparam int     KICK_HIGH_DEN   = 8;

  // reset-time levels
  localparam logic   RST_LEVEL_LOW   = 1'b0;
  localparam logic   RST_LEVEL_HIGH  = 1'b1;

  // supervisor states
  typedef enum logic [1:0] {
    SRW_RUN   = 2'b00,  // reset released, watchdog counting
    SRW_CAUSE = 2'b01,  // a level cause is present
    SRW_HOLD  = 2'b10   // cause gone, timing the hold period
  } srw_state_t;

endpackage : srw_pkg

/* rtl/srw_sync_filter.sv */
// two-stage synchroniser followed by a stable-count debouncer
`timescale 1ns/1ns
module srw_sync_filter
  import srw_pkg::*;
#(
  parameter int   STABLE_CYCLES = 1,
  parameter logic RESET_LEVEL   = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // asynchronous level in, clean level out
  input  wire logic raw_in,
  output logic      level
);

  localparam int CW = (STABLE_CYCLES > 1) ? $clog2(STABLE_CYCLES) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(STABLE_CYCLES - 1);

  // whole state of the filter
  typedef struct packed {
    logic          meta;    // first stage, read only by sync
    logic          sync;    // second stage
    logic [CW-1:0] cnt;     // cycles sync has differed from level
    logic          level;   // accepted level
  } srw_filt_t;

  srw_filt_t q;       // registered state
  srw_filt_t next_q;  // next state

  // count how long the new value has stood before accepting it
  always_comb begin
    next_q      = q;
    next_q.meta = raw_in;
    next_q.sync = q.meta;
    if (q.sync != q.level) begin
      // a bounce resets the count, so only a steady level gets through
      if (q.cnt == CNT_LAST) begin
        next_q.level = q.sync;
        next_q.cnt   = '0;
      end else begin
        next_q.cnt = q.cnt + CW'(1);
      end
    end else begin
      next_q.cnt = '0;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{meta: RESET_LEVEL, sync: RESET_LEVEL, cnt: '0, level: RESET_LEVEL};
    end else begin
      q <= next_q;
    end
  end

  assign level = q.level;

  // level only moves after the full stable count
  property p_debounce_count;
    @(posedge sys_clk) disable iff (!rst_n)
      (q.level != $past(q.level)) |-> ($past(q.cnt) == CNT_LAST && $past(q.sync) == q.level);
  endproperty
  a_debounce_count: assert property (p_debounce_count)
    else $error("filtered level changed before stable count");

endmodule : srw_sync_filter

/* rtl/srw_supervisor.sv */
// supply, manual and watchdog reset supervisor with timed reset hold
`timescale 1ns/1ns
module srw_supervisor
  import srw_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC,  // reset hold period in cycles
  parameter int WD_CYCLES   = WD_CYC,    // watchdog timeout in cycles
  parameter int MR_DEB_CYC  = MR_DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // reset causes
  input  wire logic supply_low_in,
  input  wire logic manual_reset_in_n,
  // watchdog kick pin, weakly driven by us
  input  wire logic watchdog_kick_in,
  output logic      watchdog_kick_out,
  output logic      watchdog_kick_oe,
  // reset outputs
  output logic      reset_out_n,
  output logic      reset_out
);

  // counter widths follow the periods
  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int WW = $clog2(WD_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);
  localparam logic [WW-1:0] WD_LAST   = WW'(WD_CYCLES - 1);
  // count where the internal kick driver goes high
  localparam logic [WW-1:0] WD_HIGH_AT =
    WW'((longint'(WD_CYCLES) * KICK_HIGH_NUM) / KICK_HIGH_DEN);

  // whole state of the supervisor
  typedef struct packed {
    srw_state_t    state;      // supervisor state
    logic [HW-1:0] hold_cnt;   // cycles spent in hold
    logic [WW-1:0] wd_cnt;     // watchdog time since last clear
    logic          kick_prev;  // last synchronised kick level
    logic          rst_n_q;    // active-low reset output
    logic          rst_q;      // active-high reset output
    logic          kick_drv;   // internal kick driver level
    logic          kick_oe;    // internal kick driver enable
  } srw_sup_t;

  srw_sup_t q;       // registered state
  srw_sup_t next_q;  // next state

  // clean versions of the three pins
  logic supply_low;  // synchronised supply indication
  logic mr_n;        // debounced manual reset, low = request
  logic kick;        // synchronised kick level

  // supply comparator is an async digital level
  srw_sync_filter #(
    .STABLE_CYCLES (SYNC_ONLY_CYC),
    .RESET_LEVEL   (RST_LEVEL_LOW)
  ) u_supply_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .raw_in  (supply_low_in),
    .level   (supply_low)
  );

  // switch bounce is filtered here, no outside parts needed
  srw_sync_filter #(
    .STABLE_CYCLES (MR_DEB_CYC),
    .RESET_LEVEL   (RST_LEVEL_HIGH)
  ) u_manual_deb (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .raw_in  (manual_reset_in_n),
    .level   (mr_n)
  );

  // no filtering on the kick: a 50ns pulse is five cycles
  // and must survive the two flops untouched
  srw_sync_filter #(
    .STABLE_CYCLES (SYNC_ONLY_CYC),
    .RESET_LEVEL   (RST_LEVEL_LOW)
  ) u_kick_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .raw_in  (watchdog_kick_in),
    .level   (kick)
  );

  // decoded conditions
  logic cause;      // a level reset cause is present
  logic mr_req;     // manual reset requested
  logic kick_edge;  // rising or falling kick edge
  logic wd_fire;    // watchdog ran out this cycle

  // cause and event decode
  always_comb begin
    mr_req    = !mr_n;
    cause     = supply_low || mr_req;
    kick_edge = kick != q.kick_prev;
    // fires only while released; during reset the counter is idle
    wd_fire   = (q.state == SRW_RUN) && (q.wd_cnt == WD_LAST) && !kick_edge;
  end

  // next-state logic for the whole block
  always_comb begin
    next_q           = q;
    next_q.kick_prev = kick;
    case (q.state)
      // released: watch for any cause
      SRW_RUN: begin
        if (cause) begin
          next_q.state = SRW_CAUSE;
        end else if (wd_fire) begin
          // hold counts from the start of a watchdog reset
          next_q.state    = SRW_HOLD;
          next_q.hold_cnt = '0;
        end
      end
      // level cause present: wait for it to go away
      SRW_CAUSE: begin
        if (!cause) begin
          next_q.state    = SRW_HOLD;
          next_q.hold_cnt = '0;
        end
      end
      // timing the hold; a new cause restarts everything
      SRW_HOLD: begin
        if (cause) begin
          next_q.state = SRW_CAUSE;
        end else if (q.hold_cnt == HOLD_LAST) begin
          next_q.state = SRW_RUN;
        end else begin
          next_q.hold_cnt = q.hold_cnt + HW'(1);
        end
      end
      // illegal code: treat as a live cause, safe side
      default: begin
        next_q.state = SRW_CAUSE;
      end
    endcase

    // watchdog counter: cleared during reset, on manual request, on edges
    if (next_q.state != SRW_RUN || q.state != SRW_RUN || mr_req || kick_edge) begin
      next_q.wd_cnt = '0;
    end else begin
      next_q.wd_cnt = q.wd_cnt + WW'(1);
    end

    // both outputs come from the same next state, so never disagree
    next_q.rst_n_q = (next_q.state == SRW_RUN);
    next_q.rst_q   = (next_q.state != SRW_RUN);

    // weak internal kick driver: an open pin sees an edge every
    // 7/8 period, which clears the counter before it runs out
    next_q.kick_drv = (next_q.wd_cnt >= WD_HIGH_AT);
    next_q.kick_oe  = 1'b1;
  end

  // state register; reset starts in hold as a power-on reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{state: SRW_HOLD, hold_cnt: '0, wd_cnt: '0, kick_prev: 1'b0,
             rst_n_q: 1'b0, rst_q: 1'b1, kick_drv: 1'b0, kick_oe: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from flops
  assign reset_out_n       = q.rst_n_q;
  assign reset_out         = q.rst_q;
  assign watchdog_kick_out = q.kick_drv;
  assign watchdog_kick_oe  = q.kick_oe;

  // assertions
  // all are off while rst_n is low, so the power-on hold
  // is judged only once the block has left reset

  // the two outputs are always complements
  property p_out_complement;
    @(posedge sys_clk) disable iff (!rst_n)
      reset_out == !reset_out_n;
  endproperty
  a_out_complement: assert property (p_out_complement)
    else $error("reset outputs not complementary");

  // any level cause asserts reset on the next edge
  property p_cause_asserts;
    @(posedge sys_clk) disable iff (!rst_n)
      cause |=> (!reset_out_n && reset_out);
  endproperty
  a_cause_asserts: assert property (p_cause_asserts)
    else $error("cause present but reset not asserted");

  // manual request keeps reset asserted while it lasts
  property p_manual_holds;
    @(posedge sys_clk) disable iff (!rst_n)
      (mr_req && $past(mr_req)) |-> !reset_out_n;
  endproperty
  a_manual_holds: assert property (p_manual_holds)
    else $error("manual reset low but reset released");

  // release only after the full hold count with no cause
  property p_release_after_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(reset_out_n) |-> ($past(q.hold_cnt) == HOLD_LAST && $past(q.state) == SRW_HOLD && !$past(cause));
  endproperty
  a_release_after_hold: assert property (p_release_after_hold)
    else $error("reset_out_n released before hold period");

  // active-high output falls only after the full hold count, with reset_out_n low the cycle before
  property p_high_release;
    @(posedge sys_clk) disable iff (!rst_n)
      $fell(reset_out) |-> ($past(q.hold_cnt) == HOLD_LAST && $past(reset_out_n) == 1'b0);
  endproperty
  a_high_release: assert property (p_high_release)
    else $error("reset_out released before hold period");

  // watchdog runs out into a fresh hold
  property p_wd_expire;
    @(posedge sys_clk) disable iff (!rst_n)
      (q.state == SRW_RUN && q.wd_cnt == WD_LAST && !kick_edge && !cause)
        |=> (!reset_out_n && q.state == SRW_HOLD && q.hold_cnt == '0);
  endproperty
  a_wd_expire: assert property (p_wd_expire)
    else $error("watchdog timeout did not start a reset");

  // a kick edge clears the watchdog count
  property p_kick_clears;
    @(posedge sys_clk) disable iff (!rst_n)
      kick_edge |=> (q.wd_cnt == '0);
  endproperty
  a_kick_clears: assert property (p_kick_clears)
    else $error("kick edge did not clear watchdog");

  // counter stays cleared while reset is out
  property p_wd_idle_in_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      (!reset_out_n ##1 !reset_out_n) |-> (q.wd_cnt == '0);
  endproperty
  a_wd_idle_in_reset: assert property (p_wd_idle_in_reset)
    else $error("watchdog counted during reset");

  // internal driver level tracks the counter phase
  property p_kick_drive;
    @(posedge sys_clk) disable iff (!rst_n)
      watchdog_kick_oe |-> (watchdog_kick_out == (q.wd_cnt >= WD_HIGH_AT));
  endproperty
  a_kick_drive: assert property (p_kick_drive)
    else $error("kick driver phase wrong");

  // main scenarios
  c_wd_reset:   cover property (@(posedge sys_clk) disable iff (!rst_n) wd_fire);
  c_manual_rel: cover property (@(posedge sys_clk) disable iff (!rst_n)
                  $fell(mr_req) ##1 (q.state == SRW_HOLD));
  c_supply_rel: cover property (@(posedge sys_clk) disable iff (!rst_n)
                  $fell(supply_low) ##1 (q.state == SRW_HOLD));
  c_released:   cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(reset_out_n));

endmodule : srw_supervisor

/* test/srw_mcu_model.sv */
// processor model that takes reset and services the watchdog kick pin
`timescale 1ns/1ns
module srw_mcu_model (
  // clock
  input  wire logic        sys_clk,
  // reset from the supervisor
  input  wire logic        reset_out_n,
  // behaviour chosen by the bench
  input  wire logic        kick_en,     // software alive
  input  wire logic        pulse_mode,  // short pulses instead of toggles
  input  wire logic        float_pin,   // leave the pin three-stated
  input  wire logic [15:0] kick_gap,    // cycles between kicks
  // kick pin driver
  output logic             pin_val,
  output logic             pin_oe
);
  int          gap_cnt;    // cycles since the last kick
  int          pulse_cnt;  // high cycles left in a pulse
  logic        en_q;       // bench controls as they stood at the edge
  logic        pulse_q;
  logic        float_q;
  logic [15:0] gap_q;

  initial begin
    pin_val = 1'b0;
    pin_oe = 1'b0;
    gap_cnt = 0;
    pulse_cnt = 0;
  end

  // one software step per clock, just after the edge; controls are
  // taken at the edge so the bench changing them 1 ns later never races
  always @(posedge sys_clk) begin
    en_q = kick_en;
    pulse_q = pulse_mode;
    float_q = float_pin;
    gap_q = kick_gap;
    #1;
    pin_oe = reset_out_n && !float_q;  // io floats in reset or when unused
    if (pulse_cnt > 0) begin
      pulse_cnt--;
      if (pulse_cnt == 0) pin_val = 1'b0;  // end of a 50ns pulse
    end else if (!reset_out_n || float_q) begin
      // park low and, with software alive, kick at once when driving starts, so taking the
      // pin over from the internal driver while it is low shows an edge
      pin_val = 1'b0;
      gap_cnt = 65536;
    end else if (!en_q) begin
      gap_cnt = 0;  // hung code stops servicing
    end else if (gap_cnt + 1 >= gap_q) begin
      // kick well inside the timeout
      gap_cnt = 0;
      pin_val = pulse_q ? 1'b1 : ~pin_val;
      pulse_cnt = pulse_q ? 5 : 0;
    end else begin
      gap_cnt++;
    end
  end
endmodule : srw_mcu_model

/* test/tb.sv */
// bench for the supply, manual and watchdog reset supervisor
`timescale 1ns/1ns
module tb;
  import srw_pkg::*;
  localparam int HOLD = 20;  // short hold so the run stays brief
  localparam int WD   = 64;  // short watchdog period
  localparam int DEB  = 4;   // short debounce
  logic        sys_clk, rst_n, supply_low_in, manual_reset_in_n;
  logic        kick_pin;     // resolved pin level
  logic        kick_out, kick_oe, reset_out_n, reset_out;
  logic        mcu_val, mcu_oe, kick_en, pulse_mode, float_pin;
  logic [15:0] kick_gap;
  logic        idle_tog;     // undriven pin wanders, never holds a value
  int          error_cnt, checked, n;
  logic        seen_hi;      // internal driver went high

  // weak internal driver loses to the processor
  assign kick_pin = mcu_oe ? mcu_val : (kick_oe ? kick_out : idle_tog);

  srw_supervisor #(.HOLD_CYCLES(HOLD), .WD_CYCLES(WD), .MR_DEB_CYC(DEB)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .supply_low_in(supply_low_in),
    .manual_reset_in_n(manual_reset_in_n), .watchdog_kick_in(kick_pin),
    .watchdog_kick_out(kick_out), .watchdog_kick_oe(kick_oe),
    .reset_out_n(reset_out_n), .reset_out(reset_out));

  srw_mcu_model mcu (.sys_clk(sys_clk), .reset_out_n(reset_out_n), .kick_en(kick_en),
    .pulse_mode(pulse_mode), .float_pin(float_pin), .kick_gap(kick_gap),
    .pin_val(mcu_val), .pin_oe(mcu_oe));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) idle_tog <= ~idle_tog;

  // the two reset outputs never disagree
  always @(negedge sys_clk) begin
    if (rst_n === 1'b1) begin
      checked++;
      if (reset_out !== ~reset_out_n) begin
        error_cnt++;
        $display("[ERR] %0t reset_out %h reset_out_n %h", $time, reset_out, reset_out_n);
      end
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // range compare; an unknown never passes
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask : chk

  // inputs change 1 ns after the edge, outputs are read there too
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick

  // edges until reset_out_n reaches lvl, bounded
  task automatic wait_rst(input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while (reset_out_n !== lvl) begin
      tick(1);
      cnt++;
      if (cnt > bound) begin
        error_cnt++;
        $display("[ERR] %0t reset_out_n %h expected %h timed out", $time, reset_out_n, lvl);
        tally_and_finish();
      end
    end
  endtask : wait_rst

  // reset_out_n must stay at lvl for k cycles
  task automatic steady(input logic lvl, input int k);
    int bad;
    bad = 0;
    repeat (k) begin
      tick(1);
      if (reset_out_n !== lvl) bad++;
      if (kick_out === 1'b1) seen_hi = 1'b1;
    end
    chk(bad, 0, 0);
  endtask : steady

  // block reset, then the power-on hold
  task automatic do_reset();
    rst_n = 1'b0;
    tick(5);
    chk(reset_out_n, 0, 0);
    chk(reset_out, 1, 1);
    chk(kick_oe, 0, 0);
    rst_n = 1'b1;
    // hold count already stands at zero in reset, so HOLD edges
    wait_rst(1'b1, 200, n);
    chk(n, HOLD, HOLD);
    chk(kick_oe, 1, 1);
  endtask : do_reset

  initial begin
    error_cnt = 0;
    checked = 0;
    idle_tog = 1'b0;
    seen_hi = 1'b0;
    rst_n = 1'b0;
    supply_low_in = 1'b0;
    manual_reset_in_n = 1'b1;  // manual reset line idles high until the manual test
    kick_en = 1'b0;
    pulse_mode = 1'b0;
    float_pin = 1'b1;
    kick_gap = 16'h0010;
    void'($urandom(32'h8bf3));
    do_reset();
    $display("test power_on done");
    // supply drop: two sync flops, the accept flop, then the state flop
    supply_low_in = 1'b1;
    wait_rst(1'b0, 20, n);
    chk(n, 4, 4);
    tick(10 + $urandom % 20);
    supply_low_in = 1'b0;
    wait_rst(1'b1, 200, n);
    chk(n, 4 + HOLD, 4 + HOLD);
    $display("test supply done");
    // a bounce shorter than the debounce is ignored
    manual_reset_in_n = 1'b0;
    tick(2);
    manual_reset_in_n = 1'b1;
    steady(1'b1, 30);
    manual_reset_in_n = 1'b0;
    wait_rst(1'b0, 20, n);
    chk(n, DEB + 3, DEB + 3);
    steady(1'b0, 10 + $urandom % 20);
    manual_reset_in_n = 1'b1;
    wait_rst(1'b1, 200, n);
    chk(n, HOLD + DEB + 3, HOLD + DEB + 3);
    $display("test manual done");
    // serviced watchdog: toggles, then short pulses
    float_pin = 1'b0;
    kick_en = 1'b1;
    kick_gap = 16'(8 + $urandom % (WD - 20));
    steady(1'b1, 5 * WD);
    pulse_mode = 1'b1;
    kick_gap = 16'(WD / 2);
    steady(1'b1, 5 * WD);
    pulse_mode = 1'b0;
    $display("test kick done");
    // pin left floating: internal driver keeps it serviced
    float_pin = 1'b1;
    seen_hi = 1'b0;
    steady(1'b1, 5 * WD);
    chk(seen_hi, 1, 1);
    $display("test float done");
    // software hangs: watchdog expires, holds, stays stopped in reset
    float_pin = 1'b0;
    kick_gap = 16'h0008;
    tick(20);
    kick_en = 1'b0;
    wait_rst(1'b0, 2 * WD, n);
    chk(n, WD - 10, WD + 6);
    wait_rst(1'b1, 200, n);
    chk(n, HOLD, HOLD);
    // pin parked low through the hold, so no edge: a full period
    wait_rst(1'b0, 2 * WD, n);
    chk(n, WD, WD);
    $display("test expire done");
    // block reset again in mid-run
    kick_en = 1'b1;
    do_reset();
    $display("test rerun done");
    tally_and_finish();
  end
endmodule : tb
